// File: pcrs_core.sv
// Program counter with latch bytes and hardware return address stack
`timescale 1ns/1ps
module pcrs_core
  import pcrs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire pcrs_op_e          op,
  input  wire logic [PC_W-1:0]   target,
  input  wire logic              low_wr,
  input  wire logic [7:0]        low_wdata,
  input  wire logic              low_rd,
  input  wire logic              latch_high_wr,
  input  wire logic              latch_upper_wr,
  input  wire logic [7:0]        latch_wdata,
  input  wire logic              ptr_wr,
  input  wire logic [PTR_W-1:0]  ptr_wdata,
  input  wire logic              top_low_wr,
  input  wire logic              top_high_wr,
  input  wire logic              top_upper_wr,
  input  wire logic [7:0]        top_wdata,
  input  wire logic              ovf_clr,
  input  wire logic              unf_clr,
  output logic      [PC_W-1:0]   pc,
  output logic      [7:0]        counter_low_byte,
  output logic      [7:0]        counter_high_latch,
  output logic      [7:0]        counter_upper_latch,
  output logic      [PTR_W-1:0]  return_pointer,
  output logic      [7:0]        stack_top_low,
  output logic      [7:0]        stack_top_high,
  output logic      [7:0]        stack_top_upper,
  output logic                   stack_overflow,
  output logic                   stack_underflow
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [PC_W-1:0]  pc;
    logic [7:0]       lat_high;
    logic [7:0]       lat_upper;
    logic [PTR_W-1:0] ptr;
    logic [PC_W-1:0]  top;
    logic             ovf;
    logic             unf;
  } pcrs_state_s;

  pcrs_state_s       state;
  pcrs_state_s       next_state;
  logic              ram_wr;
  logic [PTR_W-1:0]  ram_wptr;
  logic [PC_W-1:0]   ram_wdata;
  logic [PC_W-1:0]   ram_rdata;
  logic [PTR_W-1:0]  rd_ptr;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Force word alignment of any counter value
  function automatic logic [PC_W-1:0] align(input logic [PC_W-1:0] v);
    return {v[PC_W-1:1], 1'b0};
  endfunction

  // Replace one byte lane of a 21-bit word
  function automatic logic [PC_W-1:0] put_byte(
    input logic [PC_W-1:0] v,
    input int              lsb,
    input logic [7:0]      b
  );
    logic [PC_W-1:0] r;
    r = v;
    if (lsb == UPPER_LSB) begin
      r[PC_W-1:UPPER_LSB] = b[UPPER_W-1:0];
    end else begin
      r[lsb +: 8] = b;
    end
    return r;
  endfunction

  // Pointer after this cycle's operation; mirrors the next-state rules
  function automatic logic [PTR_W-1:0] ptr_after(
    input pcrs_op_e         o,
    input logic [PTR_W-1:0] p,
    input logic             wr,
    input logic [PTR_W-1:0] wd
  );
    logic [PTR_W-1:0] r;
    r = p;
    if ((o == PCRS_OP_INVOKE || o == PCRS_OP_IRQ_ACK) && p != PTR_MAX) begin
      r = p + 5'h01;
    end else if (o == PCRS_OP_EXIT && p != PTR_RESET) begin
      r = p - 5'h01;
    end else if (o == PCRS_OP_NONE && wr) begin
      r = wd;
    end
    return r;
  endfunction

  // Read address kept apart from next_state, so the storage read
  // port cannot close a loop through the next-state process
  assign rd_ptr = ptr_after(op, state.ptr, ptr_wr, ptr_wdata);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  pcrs_stack_ram u_ram (
    .clk     (clk),
    .wr_en   (ram_wr),
    .wr_ptr  (ram_wptr),
    .wr_data (ram_wdata),
    .rd_ptr  (rd_ptr),
    .rd_data (ram_rdata)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Core operations take priority over software in the same cycle
  // because the core stalls software access while it acts.
  always_comb begin
    logic [PC_W-1:0] ret;
    logic            top_hit;
    logic            ovf_set;
    logic            unf_set;
    next_state = state;
    ovf_set    = 1'b0;
    unf_set    = 1'b0;
    ram_wr     = 1'b0;
    ram_wptr   = state.ptr;
    ram_wdata  = state.top;
    ret        = align(state.pc + PC_STEP);
    top_hit    = 1'b0;

    // Sequencing of the counter and stack by the core
    unique case (op)
      PCRS_OP_NONE: begin
      end
      PCRS_OP_STEP: begin
        next_state.pc = ret;
      end
      PCRS_OP_JUMP: begin
        next_state.pc = align(target);
      end
      PCRS_OP_INVOKE, PCRS_OP_IRQ_ACK: begin
        // Return address is the following instruction
        if (op == PCRS_OP_INVOKE) begin
          next_state.pc = align(target);
        end else begin
          next_state.pc = align(target);
        end
        if (state.ptr == PTR_MAX) begin
          next_state.ovf = 1'b1;
          ovf_set        = 1'b1;
        end else begin
          next_state.ptr = state.ptr + 5'h01;
          ram_wr         = 1'b1;
          ram_wptr       = next_state.ptr;
          ram_wdata      = ret;
          top_hit        = 1'b1;
        end
      end
      PCRS_OP_EXIT: begin
        if (state.ptr == PTR_RESET) begin
          next_state.unf = 1'b1;
          unf_set        = 1'b1;
        end else begin
          next_state.pc  = align(state.top);
          next_state.ptr = state.ptr - 5'h01;
        end
      end
      default: begin
      end
    endcase

    // Software access to the counter low byte and latches
    if (op == PCRS_OP_NONE) begin
      if (latch_high_wr) begin
        next_state.lat_high = latch_wdata;
      end
      if (latch_upper_wr) begin
        next_state.lat_upper = {3'h0, latch_wdata[UPPER_W-1:0]};
      end
      if (low_rd) begin
        next_state.lat_high  = state.pc[HIGH_LSB +: 8];
        next_state.lat_upper = {3'h0, state.pc[PC_W-1:UPPER_LSB]};
      end
      if (low_wr) begin
        next_state.pc = align({state.lat_upper[UPPER_W-1:0],
                               state.lat_high, low_wdata});
      end

      // Software stack pointer and top-of-stack access
      if (ptr_wr) begin
        next_state.ptr = ptr_wdata;
      end else if (top_low_wr | top_high_wr | top_upper_wr) begin
        ram_wdata = state.top;
        if (top_low_wr) begin
          ram_wdata = put_byte(ram_wdata, LOW_LSB, top_wdata);
        end
        if (top_high_wr) begin
          ram_wdata = put_byte(ram_wdata, HIGH_LSB, top_wdata);
        end
        if (top_upper_wr) begin
          ram_wdata = put_byte(ram_wdata, UPPER_LSB, top_wdata);
        end
        ram_wr   = 1'b1;
        ram_wptr = state.ptr;
        top_hit  = 1'b1;
      end
    end

    // Top mirror follows the entry at the pointer
    if (top_hit && ram_wptr != PTR_RESET) begin
      next_state.top = ram_wdata;
    end else begin
      next_state.top = ram_rdata;
    end

    // Flag set wins over a clear in the same cycle, even when the
    // flag is already up, so a repeated fault is never lost
    if (ovf_clr && !ovf_set) begin
      next_state.ovf = 1'b0;
    end
    if (unf_clr && !unf_set) begin
      next_state.unf = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= '0;
      state.pc  <= PC_RESET;
      state.ptr <= PTR_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign pc                  = state.pc;
  assign counter_low_byte    = state.pc[7:0];
  assign counter_high_latch  = state.lat_high;
  assign counter_upper_latch = state.lat_upper;
  assign return_pointer      = state.ptr;
  assign stack_top_low       = state.top[7:0];
  assign stack_top_high      = state.top[15:8];
  assign stack_top_upper     = {3'h0, state.top[PC_W-1:UPPER_LSB]};
  assign stack_overflow      = state.ovf;
  assign stack_underflow     = state.unf;

endmodule

// File: pcrs_pkg.sv
// Shared constants and types for the program counter and return stack
package pcrs_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int PC_W    = 21;
  localparam int PTR_W   = 5;
  localparam int DEPTH   = 31;
  localparam int UPPER_W = 5;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int LOW_LSB   = 0;
  localparam int HIGH_LSB  = 8;
  localparam int UPPER_LSB = 16;
  localparam logic [PC_W-1:0]  PC_RESET  = 21'h000000;
  localparam logic [PTR_W-1:0] PTR_RESET = 5'h00;
  localparam logic [PTR_W-1:0] PTR_MAX   = 5'h1F;
  localparam logic [PC_W-1:0]  PC_STEP   = 21'h000002;

  // ---------------------------------------------------------------
  // Program counter operations from the core
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PCRS_OP_NONE,
    PCRS_OP_STEP,
    PCRS_OP_JUMP,
    PCRS_OP_INVOKE,
    PCRS_OP_IRQ_ACK,
    PCRS_OP_EXIT
  } pcrs_op_e;

endpackage

// File: pcrs_stack_ram.sv
// Return address storage, 31 words addressed by pointer values 1..31
`timescale 1ns/1ps
module pcrs_stack_ram
  import pcrs_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             wr_en,
  input  wire logic [PTR_W-1:0] wr_ptr,
  input  wire logic [PC_W-1:0]  wr_data,
  input  wire logic [PTR_W-1:0] rd_ptr,
  output logic      [PC_W-1:0]  rd_data
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Index 0 is unused so pointer zero owns no word
  logic [PC_W-1:0] mem [1:DEPTH];

  // Write port, pointer zero is never stored
  always_ff @(posedge clk) begin
    if (wr_en && wr_ptr != PTR_RESET) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  // Read port is combinational, zero reads as zero
  always_comb begin
    if (rd_ptr == PTR_RESET) begin
      rd_data = PC_RESET;
    end else begin
      rd_data = mem[rd_ptr];
    end
  end

endmodule

// File: pcrs_core_props.sv
// Concurrent checks on the program counter and return stack ports
`timescale 1ns/1ps
module pcrs_core_props
  import pcrs_pkg::*;
(
  input wire logic             clk,
  input wire logic             rst_b,
  input wire pcrs_op_e         op,
  input wire logic [PC_W-1:0]  target,
  input wire logic             low_wr,
  input wire logic [7:0]       low_wdata,
  input wire logic             low_rd,
  input wire logic [PC_W-1:0]  pc,
  input wire logic [7:0]       counter_high_latch,
  input wire logic [7:0]       counter_upper_latch,
  input wire logic [PTR_W-1:0] return_pointer,
  input wire logic [7:0]       stack_top_low,
  input wire logic [7:0]       stack_top_high,
  input wire logic [7:0]       stack_top_upper,
  input wire logic             stack_overflow,
  input wire logic             stack_underflow
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [PC_W-1:0] top;
  logic [PC_W-1:0] wval;
  logic [15:0]     pcb;
  logic            sw;
  logic            push;
  // Software inputs only count in idle cycles
  assign top  = {stack_top_upper[4:0], stack_top_high, stack_top_low};
  assign wval = {counter_upper_latch[4:0], counter_high_latch,
                 low_wdata[7:1], 1'b0};
  assign pcb  = {3'b000, pc[20:8]};
  assign sw   = (op == PCRS_OP_NONE);
  assign push = (op == PCRS_OP_INVOKE) || (op == PCRS_OP_IRQ_ACK);
  pc_even_a:
    assert property (pc[0] == 1'b0) else $error("pc odd");
  step_adv_a:
    assert property (op == PCRS_OP_STEP |=> pc == $past(pc) + PC_STEP)
    else $error("step advance wrong");
  jump_load_a:
    assert property (op == PCRS_OP_JUMP |=> pc == ($past(target) & ~21'h1))
    else $error("jump load wrong");
  push_ptr_a:
    assert property (push && return_pointer != PTR_MAX |=>
      return_pointer == $past(return_pointer) + 5'h01 &&
      top == $past(pc) + PC_STEP) else $error("push wrong");
  pop_ptr_a:
    assert property (op == PCRS_OP_EXIT && return_pointer != PTR_RESET |=>
      pc == ($past(top) & ~21'h1) &&
      return_pointer == $past(return_pointer) - 5'h01) else $error("pop wrong");
  ovf_hold_a:
    assert property (push && return_pointer == PTR_MAX |=>
      stack_overflow && return_pointer == PTR_MAX) else $error("overflow");
  unf_hold_a:
    assert property (op == PCRS_OP_EXIT && return_pointer == PTR_RESET |=>
      stack_underflow && return_pointer == PTR_RESET && $stable(pc))
    else $error("underflow");
  latch_keep_a:
    assert property (!sw |=> $stable(counter_high_latch) &&
      $stable(counter_upper_latch)) else $error("latch disturbed");
  low_write_a:
    assert property (sw && low_wr |=> pc == $past(wval))
    else $error("low write wrong");
  low_read_a:
    assert property (sw && low_rd |=>
      {counter_upper_latch, counter_high_latch} == $past(pcb))
    else $error("low read wrong");
endmodule
bind pcrs_core pcrs_core_props u_pcrs_core_props (
  .clk, .rst_b, .op, .target, .low_wr, .low_wdata, .low_rd, .pc,
  .counter_high_latch, .counter_upper_latch, .return_pointer,
  .stack_top_low, .stack_top_high, .stack_top_upper, .stack_overflow,
  .stack_underflow
);

// File: pcrs_core_model.sv
// Stand-in for the core that issues counter and stack operations
`timescale 1ns/1ps
module pcrs_core_model
  import pcrs_pkg::*;
(
  input  wire logic           clk,
  output pcrs_op_e            op,
  output logic    [PC_W-1:0]  target
);
  // Idle at time zero
  initial begin
    op = PCRS_OP_NONE;
    target = '0;
  end
  // Held across one edge; back to back calls change op once a step
  task automatic issue(input pcrs_op_e o, input logic [PC_W-1:0] t);
    op = o;
    target = t;
    @(posedge clk);
    #1;
  endtask
  // No interrupt push while software is at the stack; stale target inverted
  task automatic idle();
    op = PCRS_OP_NONE;
    target = ~target;
  endtask
endmodule

// File: tb_pcrs_core.sv
// Self-checking bench for the program counter and return stack
`timescale 1ns/1ps
module tb_pcrs_core;
  import pcrs_pkg::*;
  logic             clk = 1'b0, rst_b = 1'b0, low_wr = 1'b0, low_rd = 1'b0;
  logic             latch_high_wr = 1'b0, latch_upper_wr = 1'b0;
  logic             ptr_wr = 1'b0, top_low_wr = 1'b0, top_high_wr = 1'b0;
  logic             top_upper_wr = 1'b0, ovf_clr = 1'b0, unf_clr = 1'b0;
  logic [7:0]       low_wdata = 8'h00, latch_wdata = 8'h00, top_wdata = 8'h00;
  logic [PTR_W-1:0] ptr_wdata = 5'h00, return_pointer;
  pcrs_op_e         op;
  logic [PC_W-1:0]  target, pc, top;
  logic [7:0]       counter_low_byte, counter_high_latch, counter_upper_latch;
  logic [7:0]       stack_top_low, stack_top_high, stack_top_upper;
  logic             stack_overflow, stack_underflow;
  int               failures = 0, n_compared = 0;
  // ----------------------------------------------------------------
  // Clock, instances, shared tasks
  // ----------------------------------------------------------------
  always #2 clk = ~clk;
  assign top = {stack_top_upper[4:0], stack_top_high, stack_top_low};
  pcrs_core_model u_pcrs_core_model (.clk, .op, .target);
  pcrs_core u_pcrs_core (
    .clk, .rst_b, .op, .target, .low_wr, .low_wdata, .low_rd,
    .latch_high_wr, .latch_upper_wr, .latch_wdata, .ptr_wr, .ptr_wdata,
    .top_low_wr, .top_high_wr, .top_upper_wr, .top_wdata, .ovf_clr,
    .unf_clr, .pc, .counter_low_byte, .counter_high_latch,
    .counter_upper_latch, .return_pointer, .stack_top_low,
    .stack_top_high, .stack_top_upper, .stack_overflow, .stack_underflow
  );
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [PC_W-1:0] e, g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("pc", '0, pc);
    chk("ptr", '0, return_pointer);
    latch_wdata = 8'hA5;
    latch_high_wr = 1'b1;
    repeat (3) u_pcrs_core_model.issue(PCRS_OP_STEP, '0);
    latch_high_wr = 1'b0;
    u_pcrs_core_model.idle();
    cyc();
    chk("pc", 21'h000006, pc);
    chk("lath", 21'h00, counter_high_latch);
    $display("reset and step done");
  endtask
  // Latches feed the counter only through low byte access
  task automatic t_latch();
    latch_wdata = 8'h12;
    latch_high_wr = 1'b1;
    cyc();
    latch_high_wr = 1'b0;
    latch_upper_wr = 1'b1;
    latch_wdata = 8'hFF;
    cyc();
    latch_upper_wr = 1'b0;
    low_wdata = 8'h35;
    low_wr = 1'b1;
    cyc();
    low_wr = 1'b0;
    chk("pc", 21'h1F1234, pc);
    chk("low", 21'h34, counter_low_byte);
    u_pcrs_core_model.issue(PCRS_OP_JUMP, 21'h0A5A01);
    u_pcrs_core_model.idle();
    chk("pc", 21'h0A5A00, pc);
    low_rd = 1'b1;
    cyc();
    low_rd = 1'b0;
    chk("lath", 21'h5A, counter_high_latch);
    chk("latu", 21'h0A, counter_upper_latch);
    u_pcrs_core_model.issue(PCRS_OP_INVOKE, 21'h000100);
    u_pcrs_core_model.issue(PCRS_OP_EXIT, '0);
    u_pcrs_core_model.idle();
    chk("pc", 21'h0A5A02, pc);
    chk("lath", 21'h5A, counter_high_latch);
    $display("latch test done");
  endtask
  // Fill all 31 levels, overflow, drain, underflow, clear flags
  task automatic t_stack();
    logic [PC_W-1:0] ret [32];
    for (int i = 1; i <= 31; i++) begin
      ret[i] = pc + PC_STEP;
      u_pcrs_core_model.issue(i[0] ? PCRS_OP_IRQ_ACK : PCRS_OP_INVOKE,
                              21'(i * 64));
      chk("top", ret[i], top);
    end
    u_pcrs_core_model.issue(PCRS_OP_INVOKE, 21'h155554);
    chk("ptr", 21'h1F, return_pointer);
    chk("ovf", 21'h1, stack_overflow);
    ovf_clr = 1'b1;
    u_pcrs_core_model.issue(PCRS_OP_IRQ_ACK, 21'h0AAAA8);
    ovf_clr = 1'b0;
    chk("ovf", 21'h1, stack_overflow);
    chk("ptr", 21'h1F, return_pointer);
    for (int i = 31; i >= 1; i--) begin
      u_pcrs_core_model.issue(PCRS_OP_EXIT, '0);
      chk("pc", ret[i], pc);
    end
    u_pcrs_core_model.issue(PCRS_OP_EXIT, '0);
    chk("pc", ret[1], pc);
    chk("unf", 21'h1, stack_underflow);
    unf_clr = 1'b1;
    u_pcrs_core_model.issue(PCRS_OP_EXIT, '0);
    u_pcrs_core_model.idle();
    chk("unf", 21'h1, stack_underflow);
    chk("ptr", '0, return_pointer);
    ovf_clr = 1'b1;
    cyc();
    ovf_clr = 1'b0;
    unf_clr = 1'b0;
    chk("flags", '0, {stack_overflow, stack_underflow});
    $display("stack test done");
  endtask
  // Software builds an entry, then the core returns through it
  task automatic t_tos();
    ptr_wdata = 5'h03;
    ptr_wr = 1'b1;
    cyc();
    ptr_wr = 1'b0;
    top_wdata = 8'h1B;
    top_upper_wr = 1'b1;
    cyc();
    top_upper_wr = 1'b0;
    top_wdata = 8'hC3;
    top_high_wr = 1'b1;
    cyc();
    top_high_wr = 1'b0;
    top_wdata = 8'h5E;
    top_low_wr = 1'b1;
    cyc();
    top_low_wr = 1'b0;
    chk("top", 21'h1BC35E, top);
    u_pcrs_core_model.issue(PCRS_OP_EXIT, '0);
    u_pcrs_core_model.idle();
    chk("pc", 21'h1BC35E, pc);
    chk("ptr", 21'h02, return_pointer);
    ptr_wdata = 5'h00;
    ptr_wr = 1'b1;
    cyc();
    ptr_wr = 1'b0;
    chk("top", '0, top);
    $display("top entry test done");
  endtask
  // Main sequence, then a watchdog of 25000 cycles
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_latch();
    t_stack();
    t_tos();
    wrap_up();
  end
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
endmodule
